// ==== hdl/nvm_access_ctrl.sv ====
/*
  access controller of the byte-wide nonvolatile data memory: address, data
  and control registers, bank select and pointer one for indirect access,
  read and write cycles, write-done interrupt flags.
  assumes a cpu issuing one access per strobe on sys_clk and a free-running
  write timer clock arriving as an asynchronous pin.
*/
`timescale 1ns/1ns
`include "nvm_params.svh"

module nvm_access_ctrl
    import nvm_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1  // 1: 128 bytes, 0: 64 bytes
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // cpu data-memory access
    input wire nvm_req_s cpu_req,
    output logic [7:0] cpu_rdata,
    // interrupt handshake
    input wire logic stack_full,
    input wire logic irq_ack,
    output logic irq_request,
    // asynchronous write timer
    input wire logic nvm_timer_clk_pin,
    // status
    output logic nvm_busy
);

    // read cycle length derived from its time, rounded up
    localparam int READ_CYCLES = (`NVM_READ_NS + `NVM_CLK_NS - 1) / `NVM_CLK_NS;
    localparam logic [3:0] READ_LAST = 4'(READ_CYCLES - 1);
    localparam logic [3:0] WRITE_LAST = `NVM_WRITE_TICKS - 4'h1;
    // implemented address bits for this capacity
    localparam logic [7:0] ADDR_MASK =
        LARGE_VARIANT ? `NVM_ADDR_MASK_LARGE : `NVM_ADDR_MASK_SMALL;

    // decode one access to a register select; used for reads and writes
    function automatic nvm_sel_s nvm_decode(
        input logic indirect,
        input logic [7:0] addr,
        input logic [7:0] ptr,
        input logic bank
    );
        logic [7:0] off;
        logic eff_bank;
        nvm_sel_s s;
        off = indirect ? ptr : addr;
        eff_bank = indirect ? bank : 1'b0;
        s.ctrl = (off == `NVM_OFF_CTRL) && (eff_bank == `NVM_CTRL_BANK);
        // special-function registers answer in every bank
        s.addr = (off == `NVM_OFF_ADDR);
        s.data = (off == `NVM_OFF_DATA);
        s.ptr = (off == `NVM_OFF_PTR1);
        s.bank = (off == `NVM_OFF_BANK);
        s.irq = (off == `NVM_OFF_IRQ);
        return s;
    endfunction : nvm_decode

    // storage: flip-flops, never reset, as the cells keep their data
    logic [7:0] mem [0:`NVM_DEPTH-1];
    logic mem_we;                       // write strobe at write end

    // register state and next values
    nvm_state_e state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;      // read cycles or timer ticks
    logic [7:0] addr_reg, addr_next;    // address register
    logic [7:0] data_reg, data_next;    // data register
    logic [7:0] cap_addr_reg, cap_addr_next;  // address of running cycle
    logic [7:0] cap_data_reg, cap_data_next;  // data of running write
    logic wpermit_reg, wpermit_next;
    logic wtrig_reg, wtrig_next;
    logic rpermit_reg, rpermit_next;
    logic rtrig_reg, rtrig_next;
    logic [7:0] ptr_reg, ptr_next;      // indirect pointer one
    logic bank_reg, bank_next;          // bank select
    logic gie_reg, gie_next;            // global interrupt enable
    logic den_reg, den_next;            // done interrupt enable
    logic mfen_reg, mfen_next;          // multi-function enable
    logic done_reg, done_next;          // done request flag
    logic mf_reg, mf_next;              // multi-function request flag
    logic [7:0] rdata_reg, rdata_next;  // cpu read answer

    // timer pin synchroniser and edge detector
    logic tick_meta_reg, tick_sync_reg, tick_prev_reg;
    logic tick_edge;

    // select vector of the current access
    nvm_sel_s sel;

    // the write timer runs on its own oscillator; only its rising edge,
    // taken from the second stage, advances the write cycle
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            tick_meta_reg <= 1'b0;
            tick_sync_reg <= 1'b0;
            tick_prev_reg <= 1'b0;
        end
        else
        begin
            tick_meta_reg <= nvm_timer_clk_pin;
            tick_sync_reg <= tick_meta_reg;
            tick_prev_reg <= tick_sync_reg;
        end
    end

    assign tick_edge = tick_sync_reg & ~tick_prev_reg;

    // next-state logic of registers, flags and cycle sequencer
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        cap_addr_next = cap_addr_reg;
        cap_data_next = cap_data_reg;
        wpermit_next = wpermit_reg;
        wtrig_next = wtrig_reg;
        rpermit_next = rpermit_reg;
        rtrig_next = rtrig_reg;
        ptr_next = ptr_reg;
        bank_next = bank_reg;
        gie_next = gie_reg;
        den_next = den_reg;
        mfen_next = mfen_reg;
        done_next = done_reg;
        mf_next = mf_reg;
        rdata_next = rdata_reg;
        mem_we = 1'b0;
        sel = nvm_decode(cpu_req.indirect, cpu_req.addr, ptr_reg, bank_reg);

        // cpu writes
        if (cpu_req.wr)
        begin
            if (sel.addr)
            begin
                addr_next = cpu_req.wdata & ADDR_MASK;
            end
            if (sel.data)
            begin
                data_next = cpu_req.wdata;
            end
            if (sel.ptr)
            begin
                ptr_next = cpu_req.wdata;
            end
            if (sel.bank)
            begin
                bank_next = cpu_req.wdata[0];
            end
            if (sel.ctrl)
            begin
                wpermit_next = cpu_req.wdata[`NVM_BIT_WPERMIT];
                rpermit_next = cpu_req.wdata[`NVM_BIT_RPERMIT];
                // triggers belong to hardware while a cycle runs
                if (state_reg == NVM_IDLE)
                begin
                    // a trigger only takes if its permit is already on
                    wtrig_next = cpu_req.wdata[`NVM_BIT_WTRIG] & wpermit_reg;
                    // write wins if software breaks the one-trigger habit
                    rtrig_next = cpu_req.wdata[`NVM_BIT_RTRIG] & rpermit_reg
                        & ~wtrig_next;
                end
            end
            if (sel.irq)
            begin
                gie_next = cpu_req.wdata[`NVM_BIT_GIE];
                den_next = cpu_req.wdata[`NVM_BIT_DONE_EN];
                mfen_next = cpu_req.wdata[`NVM_BIT_MF_EN];
                done_next = cpu_req.wdata[`NVM_BIT_DONE_FLAG];
                mf_next = cpu_req.wdata[`NVM_BIT_MF_FLAG];
            end
        end

        // servicing the vector clears only the multi-function flag
        if (irq_ack)
        begin
            mf_next = 1'b0;
        end

        // cpu reads answer one cycle later from a flip-flop
        if (cpu_req.rd)
        begin
            rdata_next = 8'h00;
            if (sel.addr)
            begin
                rdata_next = addr_reg;
            end
            else if (sel.data)
            begin
                rdata_next = data_reg;
            end
            else if (sel.ptr)
            begin
                rdata_next = ptr_reg;
            end
            else if (sel.bank)
            begin
                rdata_next = {7'h00, bank_reg};
            end
            else if (sel.ctrl)
            begin
                rdata_next = {4'h0, wpermit_reg, wtrig_reg, rpermit_reg, rtrig_reg};
            end
            else if (sel.irq)
            begin
                rdata_next = {3'h0, mf_reg, done_reg, mfen_reg, den_reg, gie_reg};
            end
        end

        // cycle sequencer; its updates come last so hardware wins
        case (state_reg)
            NVM_IDLE:
            begin
                if (wtrig_reg && wpermit_reg)
                begin
                    // freeze address and data for the whole cycle
                    cap_addr_next = addr_reg;
                    cap_data_next = data_reg;
                    cnt_next = 4'h0;
                    state_next = NVM_WRITE;
                end
                else if (rtrig_reg && rpermit_reg)
                begin
                    cap_addr_next = addr_reg;
                    cnt_next = 4'h0;
                    state_next = NVM_READ;
                end
                else
                begin
                    // a permit dropped before start kills the request
                    if (!wpermit_reg)
                    begin
                        wtrig_next = 1'b0;
                    end
                    if (!rpermit_reg)
                    begin
                        rtrig_next = 1'b0;
                    end
                end
            end
            NVM_READ:
            begin
                cnt_next = cnt_reg + 4'h1;
                if (cnt_reg == READ_LAST)
                begin
                    // fetched byte overrides a same-cycle cpu data write
                    data_next = mem[cap_addr_reg[6:0]];
                    rtrig_next = 1'b0;
                    state_next = NVM_IDLE;
                end
            end
            NVM_WRITE:
            begin
                if (tick_edge)
                begin
                    cnt_next = cnt_reg + 4'h1;
                    if (cnt_reg == WRITE_LAST)
                    begin
                        mem_we = 1'b1;
                        wtrig_next = 1'b0;
                        // set wins over a clear in the same cycle
                        done_next = 1'b1;
                        mf_next = 1'b1;
                        state_next = NVM_IDLE;
                    end
                end
            end
            default:
            begin
                state_next = NVM_IDLE;
            end
        endcase
    end

    // register update; power-on clears permits, triggers and bank
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state_reg <= NVM_IDLE;
            cnt_reg <= 4'h0;
            addr_reg <= `NVM_BYTE_RESET;
            data_reg <= `NVM_BYTE_RESET;
            cap_addr_reg <= `NVM_BYTE_RESET;
            cap_data_reg <= `NVM_BYTE_RESET;
            wpermit_reg <= `NVM_CTRL_RESET;
            wtrig_reg <= `NVM_CTRL_RESET;
            rpermit_reg <= `NVM_CTRL_RESET;
            rtrig_reg <= `NVM_CTRL_RESET;
            ptr_reg <= `NVM_BYTE_RESET;
            bank_reg <= `NVM_BANK_RESET;
            gie_reg <= 1'b0;
            den_reg <= 1'b0;
            mfen_reg <= 1'b0;
            done_reg <= 1'b0;
            mf_reg <= 1'b0;
            rdata_reg <= `NVM_BYTE_RESET;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            cap_addr_reg <= cap_addr_next;
            cap_data_reg <= cap_data_next;
            wpermit_reg <= wpermit_next;
            wtrig_reg <= wtrig_next;
            rpermit_reg <= rpermit_next;
            rtrig_reg <= rtrig_next;
            ptr_reg <= ptr_next;
            bank_reg <= bank_next;
            gie_reg <= gie_next;
            den_reg <= den_next;
            mfen_reg <= mfen_next;
            done_reg <= done_next;
            mf_reg <= mf_next;
            rdata_reg <= rdata_next;
        end
    end

    // byte store; only the completed write cycle touches it
    always_ff @(posedge sys_clk)
    begin
        if (mem_we)
        begin
            mem[cap_addr_reg[6:0]] <= cap_data_reg;
        end
    end

    // outputs
    assign cpu_rdata = rdata_reg;
    assign nvm_busy = (state_reg != NVM_IDLE);
    // vector only with every enable on and room on the return stack
    assign irq_request = mf_reg & gie_reg & den_reg & mfen_reg & ~stack_full;

endmodule : nvm_access_ctrl

// ==== hdl/nvm_params.svh ====
/*
  constants of the byte-wide nonvolatile data memory access controller:
  special-function offsets, field positions, reset values and timing counts.
  assumes it is included by bare name from the controller, the checker and the bench.
*/
// Notes on behaviour
// - store 64 or 128 bytes, one byte per access
// - single-byte access via address, data, control registers
// - control register at 40H, bank 1, indirect only
// - address register 6 or 7 bits, upper zero
// - control bits 3..0 permits/triggers, reset 0
// - write trigger ignored unless write permit set
// - read trigger ignored unless read permit set
// - read end clears read trigger, data valid
// - data register holds until next operation
// - write cycle timed by asynchronous internal timer
// - write end clears write trigger by itself
// - power-on clears write permit
// - power-on bank select is bank 0
// - write end sets done and multi-function flags
// - vector needs all enables and stack room
// - service clears multi-function flag only
// - indirect uses bank select, direct bank 0
`ifndef NVM_PARAMS_SVH
`define NVM_PARAMS_SVH

// special-function offsets
`define NVM_OFF_WIN1 8'h02
`define NVM_OFF_PTR1 8'h03
`define NVM_OFF_BANK 8'h04
`define NVM_OFF_IRQ 8'h0B
`define NVM_OFF_ADDR 8'h1E
`define NVM_OFF_DATA 8'h1F
`define NVM_OFF_CTRL 8'h40
`define NVM_CTRL_BANK 1'b1

// control register fields
`define NVM_BIT_WPERMIT 3
`define NVM_BIT_WTRIG 2
`define NVM_BIT_RPERMIT 1
`define NVM_BIT_RTRIG 0

// interrupt register fields
`define NVM_BIT_GIE 0
`define NVM_BIT_DONE_EN 1
`define NVM_BIT_MF_EN 2
`define NVM_BIT_DONE_FLAG 3
`define NVM_BIT_MF_FLAG 4

// address masks for the two capacities
`define NVM_ADDR_MASK_SMALL 8'h3F
`define NVM_ADDR_MASK_LARGE 8'h7F
`define NVM_DEPTH 128

// reset values
`define NVM_CTRL_RESET 1'b0
`define NVM_BANK_RESET 1'b0
`define NVM_BYTE_RESET 8'h00

// timing
`define NVM_CLK_NS 4
`define NVM_READ_NS 8
`define NVM_WRITE_TICKS 4'h4

`endif

// ==== hdl/nvm_pkg.sv ====
/*
  types shared by the access controller: state codes, the cpu request
  carrier and the register select vector.
  assumes nvm_params.svh sits on the include path.
*/
package nvm_pkg;

    // one-hot cycle states
    typedef enum logic [2:0] {
        NVM_IDLE  = 3'b001,
        NVM_READ  = 3'b010,
        NVM_WRITE = 3'b100
    } nvm_state_e;

    // one data-memory access from the cpu
    typedef struct packed {
        logic wr;        // write strobe
        logic rd;        // read strobe
        logic indirect;  // access through window one
        logic [7:0] addr;
        logic [7:0] wdata;
    } nvm_req_s;

    // which register an access lands on
    typedef struct packed {
        logic ctrl;
        logic addr;
        logic data;
        logic ptr;
        logic bank;
        logic irq;
    } nvm_sel_s;

endpackage : nvm_pkg

// ==== dv/nvm_checker.sv ====
/*
  checker of the nvm access controller: port-level relations over time.
  assumes the bind at the foot and control writes through window one.
*/
`timescale 1ns/1ns
`include "nvm_params.svh"

module nvm_checker
    import nvm_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1  // must match the bound design
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // cpu side
    input wire nvm_req_s cpu_req,
    input wire logic [7:0] cpu_rdata,
    // interrupt side
    input wire logic stack_full,
    input wire logic irq_ack,
    input wire logic irq_request,
    // timer and status
    input wire logic nvm_timer_clk_pin,
    input wire logic nvm_busy
);
    localparam logic [7:0] ADDR_MASK =
        LARGE_VARIANT ? `NVM_ADDR_MASK_LARGE : `NVM_ADDR_MASK_SMALL;
    // shadows of pointer one, bank select and the last control byte
    logic [7:0] ptr_reg, ptr_next, ctrl_reg, ctrl_next;
    logic bank_reg, bank_next;
    logic dir_wr, ctrl_hit;  // direct write, write landing on control

    // shadow next values; only direct writes move pointer and bank
    always_comb
    begin
        dir_wr = cpu_req.wr && !cpu_req.indirect;
        ctrl_hit = cpu_req.wr && cpu_req.indirect && bank_reg && ptr_reg == `NVM_OFF_CTRL;
        ptr_next = (dir_wr && cpu_req.addr == `NVM_OFF_PTR1) ? cpu_req.wdata : ptr_reg;
        bank_next = (dir_wr && cpu_req.addr == `NVM_OFF_BANK) ? cpu_req.wdata[0] : bank_reg;
        ctrl_next = ctrl_hit ? cpu_req.wdata : ctrl_reg;
        if (!rst_n)
        begin
            ptr_next = 8'h00;
            bank_next = 1'b0;
            ctrl_next = 8'h00;
        end
    end

    // shadow registers
    always_ff @(posedge sys_clk)
    begin
        ptr_reg <= ptr_next;
        bank_reg <= bank_next;
        ctrl_reg <= ctrl_next;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // a read cycle: trigger cycle, two busy cycles, then idle
    sequence s_read_busy;
        !nvm_busy ##1 nvm_busy ##1 nvm_busy ##1 !nvm_busy;
    endsequence
    // a refused trigger leaves the block idle
    sequence s_stay_idle;
        !nvm_busy [*4];
    endsequence

    a_reset_quiet: assert property (disable iff (1'b0)
        !rst_n |=> cpu_rdata == 8'h00 && !irq_request && !nvm_busy)
        else $error("outputs not cleared by reset");
    a_irq_stack_full: assert property (stack_full |-> !irq_request)
        else $error("interrupt requested with stack full");
    a_addr_upper_zero: assert property (cpu_req.rd && !cpu_req.wr && !cpu_req.indirect
        && cpu_req.addr == `NVM_OFF_ADDR |=> (cpu_rdata & ~ADDR_MASK) == 8'h00)
        else $error("address register upper bits not zero");
    a_rdata_holds: assert property (!cpu_req.rd |=> $stable(cpu_rdata))
        else $error("read answer changed without a read");
    a_busy_bounded: assert property ($rose(nvm_busy) |-> ##[1:300] !nvm_busy)
        else $error("cycle never ended");
    a_read_start: assert property (ctrl_hit && cpu_req.wdata == 8'h03 && ctrl_reg[1]
        && !nvm_busy |-> ##1 s_read_busy)
        else $error("read cycle timing wrong");
    a_read_refused: assert property (ctrl_hit && cpu_req.wdata == 8'h01
        && !ctrl_reg[1] && !nvm_busy |-> ##1 s_stay_idle)
        else $error("read started without permit");
    a_write_refused: assert property (ctrl_hit && cpu_req.wdata == 8'h04
        && !ctrl_reg[3] && !nvm_busy |-> ##1 s_stay_idle)
        else $error("write started without permit");
    a_write_start: assert property (ctrl_hit && cpu_req.wdata == 8'h0C && ctrl_reg[3]
        && !nvm_busy |-> ##2 nvm_busy)
        else $error("write cycle did not start");
endmodule : nvm_checker

bind nvm_access_ctrl nvm_checker #(.LARGE_VARIANT(LARGE_VARIANT)) i_nvm_checker (
    .sys_clk(sys_clk), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
    .stack_full(stack_full), .irq_ack(irq_ack), .irq_request(irq_request),
    .nvm_timer_clk_pin(nvm_timer_clk_pin), .nvm_busy(nvm_busy));

// ==== dv/tb_nvm_access_ctrl.sv ====
/*
  bench of the nvm access controller: register table, refused triggers,
  write and read cycles, interrupt flags, mid-run reset.
  assumes the checker binds itself; inputs change at the falling edge.
*/
`timescale 1ns/1ns
`include "nvm_params.svh"

module tb_nvm_access_ctrl
    import nvm_pkg::*;
;
    typedef struct packed {
        logic ind;
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } nvm_row_s;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    nvm_req_s cpu_req = '0;
    logic stack_full = 1'b0;
    logic irq_ack = 1'b0;
    logic nvm_timer_clk_pin = 1'b0;
    logic [7:0] cpu_rdata;
    logic irq_request, nvm_busy;
    int n_fail = 0;
    int compares = 0;
    // write a byte then read it back: direct unless ind
    nvm_row_s rows [8] = '{'{1'b0, 8'h1E, 8'hFF, 8'h7F}, '{1'b0, 8'h1F, 8'hA5, 8'hA5},
        '{1'b0, 8'h50, 8'h33, 8'h00}, '{1'b0, 8'h03, 8'h40, 8'h40},
        '{1'b0, 8'h04, 8'h01, 8'h01}, '{1'b1, 8'h00, 8'hF0, 8'h00},
        '{1'b0, 8'h0B, 8'h07, 8'h07}, '{1'b0, 8'h40, 8'h0F, 8'h00}};

    always #2 sys_clk = ~sys_clk;
    // timer pin, unrelated in phase to the system clock
    always #17 nvm_timer_clk_pin = ~nvm_timer_clk_pin;

    nvm_access_ctrl #(.LARGE_VARIANT(1'b1)) i_nvm_access_ctrl (
        .sys_clk(sys_clk), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
        .stack_full(stack_full), .irq_ack(irq_ack), .irq_request(irq_request),
        .nvm_timer_clk_pin(nvm_timer_clk_pin), .nvm_busy(nvm_busy));

    task conclude;
        if (n_fail == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    task check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    // one strobe cycle; the idle cycle after it keeps drivers apart
    task acc(input logic wr, input logic rd, input logic ind, input logic [7:0] a,
        input logic [7:0] d);
        @(negedge sys_clk);
        cpu_req = '{wr, rd, ind, a, d};
        @(negedge sys_clk);
        cpu_req = '0;
    endtask : acc

    // the answer holds until the next read, so one extra cycle is safe
    task rdchk(input logic ind, input logic [7:0] a, input logic [7:0] exp);
        acc(1'b0, 1'b1, ind, a, 8'h00);
        @(negedge sys_clk);
        check(cpu_rdata, exp);
    endtask : rdchk

    task ctrl(input logic [7:0] d);
        acc(1'b1, 1'b0, 1'b1, 8'h00, d);
    endtask : ctrl

    // bounded wait for the end of a cycle
    task wait_idle;
        int i;
        for (i = 0; i < 400 && nvm_busy !== 1'b0; i++)
            @(negedge sys_clk);
        if (i == 400)
        begin
            n_fail++;
            $display("MISMATCH %0t cycle did not end in time", $time);
            conclude();
        end
    endtask : wait_idle

    initial
    begin
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b1;
        rdchk(1'b0, `NVM_OFF_BANK, 8'h00);
        foreach (rows[i])
        begin
            acc(1'b1, 1'b0, rows[i].ind, rows[i].a, rows[i].d);
            rdchk(rows[i].ind, rows[i].a, rows[i].e);
        end
        // triggers without permit
        ctrl(8'h04);
        rdchk(1'b1, 8'h00, 8'h00);
        ctrl(8'h01);
        rdchk(1'b1, 8'h00, 8'h00);
        // write cycle, with address and data moved while it runs
        acc(1'b1, 1'b0, 1'b0, `NVM_OFF_ADDR, 8'h05);
        acc(1'b1, 1'b0, 1'b0, `NVM_OFF_DATA, 8'h5A);
        // global enable off around the start; flags are written clear too
        acc(1'b1, 1'b0, 1'b0, `NVM_OFF_IRQ, 8'h06);
        ctrl(8'h08);
        ctrl(8'h0C);
        repeat (2) @(negedge sys_clk);
        check({7'h00, nvm_busy}, 8'h01);
        // the timer needs far longer than this, so no flag may be up yet
        acc(1'b1, 1'b0, 1'b0, `NVM_OFF_IRQ, 8'h07);
        rdchk(1'b0, `NVM_OFF_IRQ, 8'h07);
        acc(1'b1, 1'b0, 1'b0, `NVM_OFF_ADDR, 8'h06);
        acc(1'b1, 1'b0, 1'b0, `NVM_OFF_DATA, 8'h00);
        wait_idle();
        rdchk(1'b1, 8'h00, 8'h08);
        rdchk(1'b0, `NVM_OFF_IRQ, 8'h1F);
        check({7'h00, irq_request}, 8'h01);
        stack_full = 1'b1;
        @(negedge sys_clk);
        check({7'h00, irq_request}, 8'h00);
        stack_full = 1'b0;
        irq_ack = 1'b1;
        @(negedge sys_clk);
        irq_ack = 1'b0;
        rdchk(1'b0, `NVM_OFF_IRQ, 8'h0F);
        check({7'h00, irq_request}, 8'h00);
        // read back the byte written at the captured address
        ctrl(8'h02);
        acc(1'b1, 1'b0, 1'b0, `NVM_OFF_ADDR, 8'h05);
        ctrl(8'h03);
        repeat (2) @(negedge sys_clk);
        wait_idle();
        rdchk(1'b1, 8'h00, 8'h02);
        rdchk(1'b0, `NVM_OFF_DATA, 8'h5A);
        // reset in mid-run with write permit set
        ctrl(8'h08);
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        rdchk(1'b0, `NVM_OFF_BANK, 8'h00);
        acc(1'b1, 1'b0, 1'b0, `NVM_OFF_PTR1, 8'h40);
        acc(1'b1, 1'b0, 1'b0, `NVM_OFF_BANK, 8'h01);
        rdchk(1'b1, 8'h00, 8'h00);
        conclude();
    end
endmodule : tb_nvm_access_ctrl
